// ---- hdl/acmc_clk_div.sv ----
// Power-of-two divider that turns source ticks into conversion clock ticks.
// Assumes src_tick is a one-cycle enable on the bus clock.
`timescale 1ns/100ps
module acmc_clk_div (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       src_tick,
   input  wire logic [1:0] div_sel,
   output logic            div_tick
);

   acmc_pkg::acmc_div_state_t s_reg;
   acmc_pkg::acmc_div_state_t s_next;
   logic [2:0]                mask;

   // Codes 0..3 give divide by 1, 2, 4, 8
   always_comb begin
      unique case (div_sel)
         2'h0: mask = 3'h0;
         2'h1: mask = 3'h1;
         2'h2: mask = 3'h3;
         2'h3: mask = 3'h7;
      endcase
      div_tick = src_tick && ((s_reg.cnt & mask) == mask);
      s_next   = s_reg;
      if (src_tick) begin
         s_next.cnt = s_reg.cnt + 3'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

endmodule : acmc_clk_div

// ---- hdl/acmc_pkg.sv ----
// Constants, field layouts and state types of the converter clock and mode block.
// Assumes a 32-bit AHB-Lite register bus and a single 100 MHz bus clock.
package acmc_pkg;

   // Register indices; each byte address is four times the index
   localparam logic [5:0] CTRL_IDX     = 6'h02;
   localparam logic [5:0] STATUS_IDX   = 6'h04;
   localparam logic [5:0] IRQ_STAT_IDX = 6'h05;
   localparam logic [5:0] IRQ_MASK_IDX = 6'h06;
   localparam logic [5:0] RESULT_IDX   = 6'h07;

   // Values after reset
   localparam logic [7:0] CTRL_RESET     = 8'h00;
   localparam logic [2:0] IRQ_RESET      = 3'h0;

   // Event bit positions in the status and mask registers
   localparam int EVT_DONE_BIT = 0;
   localparam int EVT_FULL_BIT = 1;
   localparam int EVT_OVWR_BIT = 2;

   // Status register bit positions
   localparam int STAT_FULL_BIT  = 0;
   localparam int STAT_EMPTY_BIT = 1;
   localparam int STAT_BUSY_BIT  = 2;

   // Result queue
   localparam int         RES_W     = 12;
   localparam logic [2:0] Q_DEPTH   = 3'h4;

   // Cycle counts, in internal conversion clock ticks
   localparam logic [4:0] SHORT_SAMPLE_TICKS = 5'h04;
   localparam logic [4:0] LONG_SAMPLE_TICKS  = 5'h14;
   localparam logic [4:0] BITS_8             = 5'h08;
   localparam logic [4:0] BITS_10            = 5'h0a;
   localparam logic [4:0] BITS_12            = 5'h0c;

   // Input clock source codes
   localparam logic [1:0] SRC_BUS      = 2'h0;
   localparam logic [1:0] SRC_BUS_HALF = 2'h1;
   localparam logic [1:0] SRC_ALT      = 2'h2;
   localparam logic [1:0] SRC_ASYNC    = 2'h3;

   // Resolution codes
   localparam logic [1:0] RES_8  = 2'h0;
   localparam logic [1:0] RES_10 = 2'h1;
   localparam logic [1:0] RES_12 = 2'h2;

   // Clock and mode control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic       low_power_select;
      logic [1:0] clock_divide_select;
      logic       long_sample_select;
      logic [1:0] resolution_select;
      logic [1:0] input_clock_select;
   } acmc_ctrl_t;

   // Settings handed to the converter core
   typedef struct packed {
      logic       low_power_select;
      logic       long_sample_select;
      logic [1:0] resolution_select;
   } acmc_core_cfg_t;

   typedef enum logic [1:0] {
      ACMC_IDLE    = 2'b00,
      ACMC_SAMPLE  = 2'b01,
      ACMC_CONVERT = 2'b10
   } acmc_conv_st_t;

   typedef struct packed {
      logic [2:0] cnt;
   } acmc_div_state_t;

   typedef struct packed {
      acmc_ctrl_t                ctrl;
      acmc_ctrl_t                applied;
      acmc_conv_st_t             st;
      logic [4:0]                cnt;
      logic [3:0][RES_W-1:0]     q;
      logic [1:0]                wp;
      logic [1:0]                rp;
      logic [2:0]                count;
      logic [2:0]                irq_stat;
      logic [2:0]                irq_mask;
      logic                      dp_valid;
      logic                      dp_write;
      logic [5:0]                dp_idx;
      logic [31:0]               rdata;
      logic                      half_tgl;
      logic [1:0]                alt_sync;
      logic                      alt_prev;
      logic [1:0]                ack_sync;
      logic                      ack_prev;
   } acmc_state_t;

endpackage : acmc_pkg

// ---- hdl/acmc_top.sv ----
// Clock and mode control of the converter, its result queue and interrupt logic.
// Assumes an AHB-Lite master on clk, alternate and async clocks arriving as pins,
// and a converter core that holds sar_result stable while a conversion runs.
`timescale 1ns/100ps

// Functional notes
// - With the result queue holding all its entries the full flag is high and a new result replaces the oldest one.
// - Below full the flag is low and each new result is stored with no older entry lost.
// - Bit 7 picks the high-speed converter setting at 0 and the reduced-power, slower setting at 1.
// - Bits 6 to 5 divide the chosen input clock by 1, 2, 4 or 8 to make the conversion clock.
// - Bit 4 picks a short sampling period at 0 and a longer one at 1, stretching the conversion.
// - Bits 3 to 2 pick 8, 10 or 12 bit results, with code 11 reserved.
// - Bits 1 to 0 pick bus clock, bus clock halved, alternate clock or the converter's own clock.
// - The control register reads and writes all eight bits and is zero after reset.
module acmc_top (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   // AHB-Lite slave
   input  wire logic                     hsel,
   input  wire logic [31:0]              haddr,
   input  wire logic [1:0]               htrans,
   input  wire logic                     hwrite,
   input  wire logic [2:0]               hsize,
   input  wire logic [31:0]              hwdata,
   input  wire logic                     hready,
   output logic                          hreadyout,
   output logic                          hresp,
   output logic [31:0]                   hrdata,
   // Clock sources from outside the bus clock domain
   input  wire logic                     alternate_clock,
   input  wire logic                     converter_async_clock,
   // Converter core
   input  wire logic                     conv_start,
   input  wire logic [11:0]              sar_result,
   output acmc_pkg::acmc_core_cfg_t      core_cfg,
   output logic                          internal_conversion_clock,
   output logic                          conversion_busy,
   output logic                          result_queue_full_flag,
   output logic                          irq
);

   acmc_pkg::acmc_state_t s_reg;
   acmc_pkg::acmc_state_t s_next;

   logic        src_tick;
   logic        conv_tick;
   logic        take;
   logic [5:0]  take_idx;
   logic        pop;
   logic        push;
   logic        overwrite;
   logic [2:0]  count_n;
   logic [1:0]  rp_n;
   logic [2:0]  irq_clr;
   logic [2:0]  evt;
   logic [4:0]  n_bits;
   logic [11:0] res_masked;

   // Divider runs from the latched source; its code only changes while idle
   acmc_clk_div acmc_clk_div_inst (
      .clk      (clk),
      .rst_n    (rst_n),
      .src_tick (src_tick),
      .div_sel  (s_reg.applied.clock_divide_select),
      .div_tick (conv_tick)
   );

   // Source tick selection; pin clocks are edge detected after the second flop
   always_comb begin
      unique case (s_reg.applied.input_clock_select)
         acmc_pkg::SRC_BUS:      src_tick = 1'b1;
         acmc_pkg::SRC_BUS_HALF: src_tick = s_reg.half_tgl;
         acmc_pkg::SRC_ALT:      src_tick = s_reg.alt_sync[1] & ~s_reg.alt_prev;
         acmc_pkg::SRC_ASYNC:    src_tick = s_reg.ack_sync[1] & ~s_reg.ack_prev;
      endcase
   end

   // Bits per result from the latched resolution; reserved code runs as 12
   always_comb begin
      unique case (s_reg.applied.resolution_select)
         acmc_pkg::RES_8: begin
            n_bits     = acmc_pkg::BITS_8;
            res_masked = {4'h0, sar_result[7:0]};
         end
         acmc_pkg::RES_10: begin
            n_bits     = acmc_pkg::BITS_10;
            res_masked = {2'h0, sar_result[9:0]};
         end
         default: begin
            n_bits     = acmc_pkg::BITS_12;
            res_masked = sar_result;
         end
      endcase
   end

   // Bus address phase decode
   assign take     = hsel && htrans[1] && hready;
   assign take_idx = haddr[7:2];
   assign pop      = take && !hwrite && (take_idx == acmc_pkg::RESULT_IDX) && (s_reg.count != 3'h0);

   // Whole next state
   always_comb begin
      s_next    = s_reg;
      push      = 1'b0;
      overwrite = 1'b0;
      irq_clr   = 3'h0;
      evt       = 3'h0;

      // Synchronisers and the halved bus clock
      s_next.half_tgl = ~s_reg.half_tgl;
      s_next.alt_sync = {s_reg.alt_sync[0], alternate_clock};
      s_next.alt_prev = s_reg.alt_sync[1];
      s_next.ack_sync = {s_reg.ack_sync[0], converter_async_clock};
      s_next.ack_prev = s_reg.ack_sync[1];

      // Conversion sequencer, counting conversion clock ticks
      unique case (s_reg.st)
         acmc_pkg::ACMC_IDLE: begin
            s_next.applied = s_reg.ctrl;
            if (conv_start) begin
               s_next.st  = acmc_pkg::ACMC_SAMPLE;
               s_next.cnt = s_reg.ctrl.long_sample_select ? acmc_pkg::LONG_SAMPLE_TICKS - 5'h01
                                                           : acmc_pkg::SHORT_SAMPLE_TICKS - 5'h01;
            end
         end
         acmc_pkg::ACMC_SAMPLE: begin
            if (conv_tick) begin
               if (s_reg.cnt == 5'h00) begin
                  s_next.st  = acmc_pkg::ACMC_CONVERT;
                  s_next.cnt = n_bits - 5'h01;
               end else begin
                  s_next.cnt = s_reg.cnt - 5'h01;
               end
            end
         end
         acmc_pkg::ACMC_CONVERT: begin
            if (conv_tick) begin
               if (s_reg.cnt == 5'h00) begin
                  s_next.st = acmc_pkg::ACMC_IDLE;
                  push      = 1'b1;
               end else begin
                  s_next.cnt = s_reg.cnt - 5'h01;
               end
            end
         end
         default: begin
            s_next.st = acmc_pkg::ACMC_IDLE;
         end
      endcase

      // Result queue; a pop in the same cycle frees room before the push
      count_n = s_reg.count;
      rp_n    = s_reg.rp;
      if (pop) begin
         rp_n    = s_reg.rp + 2'h1;
         count_n = s_reg.count - 3'h1;
      end
      if (push) begin
         s_next.q[s_reg.wp] = res_masked;
         s_next.wp          = s_reg.wp + 2'h1;
         if (count_n == acmc_pkg::Q_DEPTH) begin
            rp_n      = rp_n + 2'h1;
            overwrite = 1'b1;
         end else begin
            count_n = count_n + 3'h1;
         end
      end
      s_next.rp    = rp_n;
      s_next.count = count_n;

      // Events
      evt[acmc_pkg::EVT_DONE_BIT] = push;
      evt[acmc_pkg::EVT_FULL_BIT] = push && !overwrite && (count_n == acmc_pkg::Q_DEPTH);
      evt[acmc_pkg::EVT_OVWR_BIT] = overwrite;

      // Data phase of a write
      if (s_reg.dp_valid && s_reg.dp_write) begin
         unique case (s_reg.dp_idx)
            acmc_pkg::CTRL_IDX:     s_next.ctrl = acmc_pkg::acmc_ctrl_t'(hwdata[7:0]);
            acmc_pkg::IRQ_STAT_IDX: irq_clr = hwdata[2:0];
            acmc_pkg::IRQ_MASK_IDX: s_next.irq_mask = hwdata[2:0];
            default:                s_next.ctrl = s_reg.ctrl;
         endcase
      end
      // Set wins over a clear in the same cycle
      s_next.irq_stat = (s_reg.irq_stat & ~irq_clr) | evt;

      // Address phase; read data is captured now and shown in the data phase
      s_next.dp_valid = take;
      if (take) begin
         s_next.dp_write = hwrite;
         s_next.dp_idx   = take_idx;
      end
      if (take && !hwrite) begin
         unique case (take_idx)
            acmc_pkg::CTRL_IDX:     s_next.rdata = {24'h000000, s_reg.ctrl};
            acmc_pkg::STATUS_IDX: begin
               s_next.rdata                           = 32'h00000000;
               s_next.rdata[acmc_pkg::STAT_FULL_BIT]  = (s_reg.count == acmc_pkg::Q_DEPTH);
               s_next.rdata[acmc_pkg::STAT_EMPTY_BIT] = (s_reg.count == 3'h0);
               s_next.rdata[acmc_pkg::STAT_BUSY_BIT]  = (s_reg.st != acmc_pkg::ACMC_IDLE);
            end
            acmc_pkg::IRQ_STAT_IDX: s_next.rdata = {29'h00000000, s_reg.irq_stat};
            acmc_pkg::IRQ_MASK_IDX: s_next.rdata = {29'h00000000, s_reg.irq_mask};
            acmc_pkg::RESULT_IDX:   s_next.rdata = (s_reg.count != 3'h0) ? {20'h00000, s_reg.q[s_reg.rp]}
                                                                         : 32'h00000000;
            default:                s_next.rdata = 32'h00000000;
         endcase
      end
   end

   // One register stage for all state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg          <= '0;
         s_reg.ctrl     <= acmc_pkg::acmc_ctrl_t'(acmc_pkg::CTRL_RESET);
         s_reg.applied  <= acmc_pkg::acmc_ctrl_t'(acmc_pkg::CTRL_RESET);
         s_reg.st       <= acmc_pkg::ACMC_IDLE;
         s_reg.irq_stat <= acmc_pkg::IRQ_RESET;
         s_reg.irq_mask <= acmc_pkg::IRQ_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   // Zero wait states and always OKAY, so no stall path exists
   assign hreadyout                  = 1'b1;
   assign hresp                      = 1'b0;
   assign hrdata                     = s_reg.rdata;
   assign core_cfg.low_power_select  = s_reg.applied.low_power_select;
   assign core_cfg.long_sample_select = s_reg.applied.long_sample_select;
   assign core_cfg.resolution_select = s_reg.applied.resolution_select;
   assign internal_conversion_clock  = conv_tick;
   assign conversion_busy            = (s_reg.st != acmc_pkg::ACMC_IDLE);
   assign result_queue_full_flag     = (s_reg.count == acmc_pkg::Q_DEPTH);
   assign irq                        = |(s_reg.irq_stat & s_reg.irq_mask);

endmodule : acmc_top

// ---- testbench/acmc_top_bench.sv ----
// Bench for acmc_top: registers, conversion length per mode, queue, interrupt.
// Assumes the checker binds itself; pin clocks are made here.
`timescale 1ns/100ps
module acmc_top_bench;
   logic                     clk        = 1'b0;
   logic                     rst_n      = 1'b0;
   logic                     hsel       = 1'b0;
   logic [31:0]              haddr      = 32'h0;
   logic [1:0]               htrans     = 2'h0;
   logic                     hwrite     = 1'b0;
   logic [31:0]              hwdata     = 32'h0;
   logic                     alt_clk    = 1'b0;
   logic                     async_clk  = 1'b0;
   logic                     conv_start = 1'b0;
   logic [11:0]              sar_result = 12'h0;
   logic                     hreadyout, tick, busy, full, irq;
   logic [31:0]              hrdata, rd;
   logic [3:0]               cfg_e;
   acmc_pkg::acmc_core_cfg_t core_cfg;
   logic [7:0]               modes [11] = '{8'h00, 8'h14, 8'h08, 8'h0c, 8'h20, 8'h40, 8'h60, 8'h01, 8'h22, 8'h03, 8'h84};
   int                       width [4]  = '{8, 10, 12, 12};
   int                       src_per [4] = '{1, 2, 6, 10};
   int                       miscompares = 0, cmp_count = 0, cyc = 0, t0, n, ticks, per;

   acmc_top acmc_top_inst (
      .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(),
      .hrdata(hrdata), .alternate_clock(alt_clk), .converter_async_clock(async_clk),
      .conv_start(conv_start), .sar_result(sar_result), .core_cfg(core_cfg),
      .internal_conversion_clock(tick), .conversion_busy(busy), .result_queue_full_flag(full), .irq(irq)
   );

   always #5 clk = ~clk;

   // Pin clocks of period 6 and 10 cycles, and the hang limit
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc % 3 == 0) alt_clk <= ~alt_clk;
      if (cyc % 5 == 0) async_clk <= ~async_clk;
      if (cyc == 20000) begin
         miscompares++;
         wrap_up();
      end
   end

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : wrap_up

   task automatic check(input string what, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
      cmp_count++;
      if ($isunknown(got) || got < lo || got > hi) begin
         miscompares++;
         $display("wrong value %s expected %0h..%0h seen %0h", what, lo, hi, got);
      end
   endtask : check

   // Single word transfer; waits on hready rather than assuming zero waits
   task automatic xfer(input logic [5:0] idx, input logic wr, input logic [31:0] wd);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : xfer

   task automatic rchk(input logic [5:0] idx, input logic [31:0] exp);
      xfer(idx, 1'b0, 32'h0);
      check($sformatf("register %0h", idx), exp, exp, rd);
   endtask : rchk

   // One mid-cycle sample after two falling edges, in case the level is registered once more
   task automatic irq_chk(input logic exp);
      repeat (2) @(negedge clk);
      check("irq", {31'h0, exp}, {31'h0, exp}, {31'h0, irq});
   endtask : irq_chk

   task automatic convert(input logic [11:0] val);
      @(posedge clk);
      sar_result <= val;
      conv_start <= 1'b1;
      @(posedge clk);
      conv_start <= 1'b0;
      t0 = cyc;
   endtask : convert

   // Busy cycles counted mid-cycle, clear of the edge updates
   task automatic finish_conv;
      do @(negedge clk); while (busy === 1'b1);
      n = cyc - t0 - 1;
   endtask : finish_conv

   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rchk(acmc_pkg::CTRL_IDX, 32'h0);
      rchk(acmc_pkg::STATUS_IDX, 32'h2);
      xfer(acmc_pkg::CTRL_IDX, 1'b1, 32'hffff_ff5a);
      rchk(acmc_pkg::CTRL_IDX, 32'h5a);
      xfer(6'h3f, 1'b1, 32'hffff_ffff);
      rchk(6'h3f, 32'h0);
      $display("test registers done");
      // Each source, divide, sample and width code; first tick may come early
      for (int i = 0; i < 11; i++) begin
         xfer(acmc_pkg::CTRL_IDX, 1'b1, {24'h0, modes[i]});
         repeat (6) @(posedge clk);
         ticks = (modes[i][4] ? 20 : 4) + width[modes[i][3:2]];
         per = src_per[modes[i][1:0]] << modes[i][6:5];
         cfg_e = {modes[i][7], modes[i][4], modes[i][3:2]};
         convert(12'h0);
         @(negedge clk);
         check("core settings", {28'h0, cfg_e}, {28'h0, cfg_e}, {28'h0, core_cfg});
         finish_conv;
         check("busy cycles", (ticks - 1) * per + 1, ticks * per, n);
      end
      $display("test modes done");
      // New divider and a second start while busy leave the run alone
      xfer(acmc_pkg::CTRL_IDX, 1'b1, 32'h0);
      convert(12'h0);
      xfer(acmc_pkg::CTRL_IDX, 1'b1, 32'h60);
      conv_start <= 1'b1;
      @(posedge clk);
      conv_start <= 1'b0;
      finish_conv;
      check("busy cycles", 32'd12, 32'd12, n);
      rchk(acmc_pkg::CTRL_IDX, 32'h60);
      $display("test frozen settings done");
      repeat (4) xfer(acmc_pkg::RESULT_IDX, 1'b0, 32'h0);
      irq_chk(1'b0);
      xfer(acmc_pkg::IRQ_MASK_IDX, 1'b1, 32'h7);
      irq_chk(1'b1);
      xfer(acmc_pkg::IRQ_STAT_IDX, 1'b1, 32'h7);
      rchk(acmc_pkg::IRQ_STAT_IDX, 32'h0);
      irq_chk(1'b0);
      xfer(acmc_pkg::CTRL_IDX, 1'b1, 32'h08);
      for (int i = 1; i < 6; i++) begin
         convert(12'h111 * i[11:0]);
         finish_conv;
         check("full flag", {31'h0, i > 3}, {31'h0, i > 3}, {31'h0, full});
      end
      rchk(acmc_pkg::IRQ_STAT_IDX, 32'h7);
      rchk(acmc_pkg::STATUS_IDX, 32'h1);
      for (int i = 2; i < 6; i++) rchk(acmc_pkg::RESULT_IDX, 32'h111 * i);
      rchk(acmc_pkg::STATUS_IDX, 32'h2);
      $display("test queue done");
      wrap_up();
   end
endmodule : acmc_top_bench

// ---- testbench/acmc_top_sva.sv ----
// Checker for acmc_top: bus answer, conversion length, queue fill, tick rate.
// Assumes binding to acmc_top with hready fed back from hreadyout.
`timescale 1ns/100ps
module acmc_top_sva (
   input wire logic                     clk,
   input wire logic                     rst_n,
   input wire logic                     hsel,
   input wire logic [31:0]              haddr,
   input wire logic [1:0]               htrans,
   input wire logic                     hwrite,
   input wire logic [31:0]              hwdata,
   input wire logic                     hready,
   input wire logic                     hreadyout,
   input wire logic                     hresp,
   input wire logic                     conv_start,
   input wire acmc_pkg::acmc_core_cfg_t core_cfg,
   input wire logic                     internal_conversion_clock,
   input wire logic                     conversion_busy,
   input wire logic                     result_queue_full_flag
);
   logic       wr_ph;
   logic       pop_d;
   logic       busy_d;
   logic [7:0] ctrl_m;
   logic [2:0] q_m;
   logic [2:0] q_nx;
   logic [2:0] settle;
   logic [4:0] tcnt;
   logic [4:0] need;
   wire        take = hsel && htrans[1] && hready;

   // Queue count one cycle late, and ticks a conversion must take
   always_comb begin
      q_nx = q_m - {2'h0, pop_d && q_m != 3'h0};
      if (busy_d && !conversion_busy && q_nx != 3'h4) begin
         q_nx = q_nx + 3'h1;
      end
      need = core_cfg.long_sample_select ? 5'h14 : 5'h04;
      need = need + (core_cfg.resolution_select == 2'h0 ? 5'h08 : core_cfg.resolution_select == 2'h1 ? 5'h0a : 5'h0c);
   end

   // Settle count guards checks until applied settings catch up
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {wr_ph, pop_d, busy_d, ctrl_m, q_m, settle, tcnt} <= '0;
      end else begin
         wr_ph  <= take && hwrite && haddr[7:2] == acmc_pkg::CTRL_IDX;
         pop_d  <= take && !hwrite && haddr[7:2] == acmc_pkg::RESULT_IDX;
         busy_d <= conversion_busy;
         ctrl_m <= wr_ph ? hwdata[7:0] : ctrl_m;
         q_m    <= q_nx;
         settle <= (wr_ph || conversion_busy) ? 3'h0 : (settle == 3'h4 ? settle : settle + 3'h1);
         tcnt   <= conversion_busy ? tcnt + {4'h0, internal_conversion_clock} : 5'h00;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready okay");
   chk_start_busy: assert property (conv_start && !conversion_busy |=> conversion_busy)
      else $error("start while idle not taken");
   chk_cfg_frozen: assert property (conversion_busy && $past(conversion_busy) |-> $stable(core_cfg))
      else $error("settings moved mid conversion");
   chk_conv_end: assert property (conversion_busy && internal_conversion_clock && tcnt == need - 5'h01
      |=> !conversion_busy)
      else $error("conversion overran its ticks");
   chk_conv_bound: assert property (conversion_busy |-> tcnt < need)
      else $error("conversion tick count exceeded");
   chk_full_track: assert property ((q_m == 3'h4) == $past(result_queue_full_flag))
      else $error("full flag disagrees with queue count");
   chk_cfg_follow: assert property (settle == 3'h4 |-> core_cfg == {ctrl_m[7], ctrl_m[4], ctrl_m[3:2]})
      else $error("core settings differ from control");
   chk_tick_full: assert property (settle == 3'h4 && ctrl_m[6:5] == 2'h0 && ctrl_m[1:0] == 2'h0
      |-> internal_conversion_clock)
      else $error("undivided bus clock tick missing");

   cov_full: cover property ($rose(result_queue_full_flag));
   cov_long: cover property (conversion_busy && core_cfg.long_sample_select);
   cov_half: cover property (settle == 3'h4 && ctrl_m[1:0] == 2'h1);
endmodule : acmc_top_sva

bind acmc_top acmc_top_sva acmc_top_sva_inst (
   .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .conv_start(conv_start),
   .core_cfg(core_cfg), .internal_conversion_clock(internal_conversion_clock),
   .conversion_busy(conversion_busy), .result_queue_full_flag(result_queue_full_flag)
);
